// >>> hdl/pic_pkg.sv
// Notes on behaviour
// - op-end request enters level 5 after execution
// - level 7 program check ranks first
// - levels 6,4,3,2 rank second to fifth
// - level 5 ranks sixth, also diskette ready
// - level 1 keyboard/display ranks seventh
// - level 0 supervisor ranks eighth, main below
// - five errors raise a program check
// - check inside level 7 gives hard stop
// - cycle-steal invalid address always hard stops
// - disabled program check makes errors hard stop
// - command disables check and resets level 7
// - capture check code, address and level
// - mask bit holds higher requests pending
// - mask never holds off level 7
// - level reset with mask set is ignored
// - check sets indicator, stops, shows cause
// - only reset, check reset, load clear stop
// - stop abandons in-flight I/O transfers
// - attention lit, processor runs, starts rejected
// - disk not ready advances level or repeats
// - each level owns address, recall, mode registers
package pic_pkg;

	localparam int APB_AW = 8;
	localparam int ADDR_W = 16;
	localparam int PHYS_W = 19;
	localparam int N_CTX  = 9;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_CHK_CODE  = 8'h08;
	localparam logic [7:0] OFS_CHK_ADDR  = 8'h0C;
	localparam logic [7:0] OFS_CHK_LEVEL = 8'h10;
	localparam logic [7:0] OFS_LEVEL_SEL = 8'h14;
	localparam logic [7:0] OFS_NEXT_PTR  = 8'h18;
	localparam logic [7:0] OFS_BR_HOLD   = 8'h1C;
	localparam logic [7:0] OFS_MODE      = 8'h20;

	// control register bits
	localparam int CTRL_PC_ENABLE  = 0;
	localparam int CTRL_PC_DISABLE = 1;
	localparam int CTRL_RESET_L7   = 2;
	localparam int CTRL_RESET_CUR  = 3;

	localparam int MODE_MASK_BIT = 0;
	localparam int MODE_W        = 8;

	localparam logic [3:0] LVL_MAIN  = 4'h8;
	localparam logic [3:0] RANK_MAIN = 4'h8;
	localparam logic [7:0] MODE_RST  = 8'h00;

	// levels in falling priority
	localparam logic [2:0] LVL_BY_RANK [8] = '{3'h7, 3'h6, 3'h4, 3'h3, 3'h2, 3'h5, 3'h1, 3'h0};

	typedef enum logic [2:0] {
		PIC_CHK_INV_ADDR,
		PIC_CHK_INV_Q,
		PIC_CHK_INV_OP,
		PIC_CHK_PRIV_OP,
		PIC_CHK_STOR_VIOL,
		PIC_CHK_CS_ADDR,
		PIC_CHK_NONE
	} pic_check_e;

	typedef struct packed {
		logic              valid;
		pic_check_e        code;
		logic [PHYS_W-1:0] addr;
	} pic_check_s;

endpackage

// >>> hdl/pic_ctrl.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pic_ctrl #(
	parameter bit HAS_LEVEL6 = 1'b1
) (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [pic_pkg::APB_AW-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// attachments on the channel, asynchronous
	input  wire logic                          op_end_req,
	input  wire logic                          diskette_ready_req,
	input  wire logic [4:0]                    io_level_req,
	input  wire logic                          io_attention,
	input  wire logic                          disk_not_ready,
	// panel and maintenance, asynchronous
	input  wire logic                          check_reset_key,
	input  wire logic                          initial_program_load,
	input  wire logic                          dual_program_active,
	// instruction sequencer, same clock
	input  wire logic                          insn_end,
	input  wire logic                          svc_req,
	input  wire pic_pkg::pic_check_s           check_report,
	input  wire logic                          cs_invalid_addr,
	input  wire logic [pic_pkg::PHYS_W-1:0]    cs_addr,
	input  wire logic                          seq_ptr_we,
	input  wire logic [pic_pkg::ADDR_W-1:0]    seq_ptr,
	input  wire logic                          seq_hold_we,
	input  wire logic [pic_pkg::ADDR_W-1:0]    seq_hold,
	// toward the sequencer and panel
	output logic      [pic_pkg::ADDR_W-1:0]    next_instruction_pointer,
	output logic      [pic_pkg::ADDR_W-1:0]    branch_address_holder,
	output logic      [3:0]                    active_level,
	output logic                               level_switch,
	output logic                               proc_stop,
	output logic                               check_indicator,
	output pic_pkg::pic_check_e                stop_check_code,
	output logic                               io_abort,
	output logic                               attention_indicator,
	output logic                               start_io_reject,
	output logic                               advance_program_level,
	output logic                               repeat_instruction
);
	import pic_pkg::*;

	// synchronisers for pins
	// every asynchronous pin crosses here; only sync_q reads meta_q
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {dual_program_active, initial_program_load, check_reset_key,
				disk_not_ready, io_attention, io_level_req, diskette_ready_req, op_end_req};
			sync_q <= meta_q;
		end
	end
	logic       s_opend;
	logic       s_dsk;
	logic [4:0] s_lvl;
	logic       s_attn;
	logic       s_dnr;
	logic       s_chkrst;
	logic       s_load;
	logic       s_dual;
	assign s_opend  = sync_q[0];
	assign s_dsk    = sync_q[1];
	assign s_lvl    = sync_q[6:2];
	assign s_attn   = sync_q[7];
	assign s_dnr    = sync_q[8];
	assign s_chkrst = sync_q[9];
	assign s_load   = sync_q[10];
	assign s_dual   = sync_q[11];

	// per-level context; index 8 is the main program
	logic [ADDR_W-1:0] ptr_q  [N_CTX];
	logic [ADDR_W-1:0] hold_q [N_CTX];
	logic [MODE_W-1:0] mode_q [N_CTX];

	logic [7:0]        in_level_q;
	logic              pc_en_q;
	logic              pc_pend_q;
	logic              svc_pend_q;
	logic              stop_q;
	pic_check_e        stop_code_q;
	pic_check_e        chk_code_q;
	logic [PHYS_W-1:0] chk_addr_q;
	logic [3:0]        chk_level_q;
	logic [3:0]        level_sel_q;
	logic              dnr_seen_q;

	// apb decode
	logic       apb_setup;
	logic       apb_wr;
	logic       apb_rd_phase;
	logic       addr_ok;
	logic       sel_ok;
	logic [3:0] sel_idx;
	assign apb_setup    = psel && penable && !pready;
	assign apb_wr       = psel && penable && pready && pwrite && !pslverr;
	assign apb_rd_phase = apb_setup;
	assign sel_ok       = level_sel_q <= LVL_MAIN;
	assign sel_idx      = sel_ok ? level_sel_q : LVL_MAIN;
	always_comb begin
		unique case (paddr)
			OFS_CTRL, OFS_STATUS, OFS_CHK_CODE, OFS_CHK_ADDR, OFS_CHK_LEVEL,
			OFS_LEVEL_SEL, OFS_NEXT_PTR, OFS_BR_HOLD, OFS_MODE: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	logic ctrl_wr;
	assign ctrl_wr = apb_wr && paddr == OFS_CTRL;

	// current level: highest ranked active level, else main
	logic [3:0] cur_lvl;
	logic [3:0] cur_rank;
	always_comb begin
		cur_lvl  = LVL_MAIN;
		cur_rank = RANK_MAIN;
		for (int r = 7; r >= 0; r--) begin
			if (in_level_q[LVL_BY_RANK[r]]) begin
				cur_lvl  = {1'b0, LVL_BY_RANK[r]};
				cur_rank = 4'(r);
			end
		end
	end

	logic cur_masked;
	assign cur_masked = mode_q[cur_lvl][MODE_MASK_BIT];

	// pending requests by level
	logic [7:0] req;
	always_comb begin
		req    = '0;
		req[7] = pc_pend_q;
		req[6] = HAS_LEVEL6 && s_lvl[4];
		req[5] = s_opend || s_dsk;
		req[4] = s_lvl[3];
		req[3] = s_lvl[2];
		req[2] = s_lvl[1];
		req[1] = s_lvl[0];
		req[0] = svc_pend_q;
	end

	// pick the best eligible request above the current level
	logic       pick_valid;
	logic [2:0] pick_lvl;
	always_comb begin
		pick_valid = 1'b0;
		pick_lvl   = 3'h0;
		for (int r = 0; r < 8; r++) begin
			// rank order puts level 7 first
			if (!pick_valid && req[LVL_BY_RANK[r]] && 4'(r) < cur_rank &&
			    (LVL_BY_RANK[r] == 3'h7 || !cur_masked)) begin
				pick_valid = 1'b1;
				pick_lvl   = LVL_BY_RANK[r];
			end
		end
	end

	logic take;
	// entry only at an instruction boundary, never mid-execution
	assign take = insn_end && pick_valid && !stop_q;

	// check classification
	// a stop outranks entry, so a stopped machine never enters level 7
	logic chk_evt;
	logic chk_to_stop;
	logic chk_to_l7;
	assign chk_evt     = check_report.valid && check_report.code <= PIC_CHK_STOR_VIOL;
	assign chk_to_stop = chk_evt && (!pc_en_q || cur_lvl == 4'h7);
	assign chk_to_l7   = chk_evt && !chk_to_stop && !stop_q;

	logic stop_clear;
	assign stop_clear = s_chkrst || s_load;

	// level activity
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			in_level_q <= '0;
		end else if (s_load) begin
			in_level_q <= '0;
		end else begin
			logic [7:0] nxt;
			nxt = in_level_q;
			// a masked level cannot be left: software unmasks first
			if (ctrl_wr && pwdata[CTRL_RESET_CUR] && cur_lvl != LVL_MAIN && !cur_masked)
				nxt[cur_lvl[2:0]] = 1'b0;
			if (ctrl_wr && pwdata[CTRL_RESET_L7] && !mode_q[7][MODE_MASK_BIT])
				nxt[7] = 1'b0;
			if (take)
				nxt[pick_lvl] = 1'b1;
			in_level_q <= nxt;
		end
	end

	// program check enable, pending level 7, supervisor call
	always_ff @(posedge sys_clk) begin
		if (sys_rst || s_load) begin
			pc_en_q <= 1'b0;
		end else if (ctrl_wr && pwdata[CTRL_PC_DISABLE]) begin
			pc_en_q <= 1'b0;
		end else if (ctrl_wr && pwdata[CTRL_PC_ENABLE]) begin
			pc_en_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || s_load) begin
			pc_pend_q  <= 1'b0;
			svc_pend_q <= 1'b0;
		end else begin
			// set wins over the clear from entry
			pc_pend_q  <= chk_to_l7 || (pc_pend_q && !(take && pick_lvl == 3'h7));
			svc_pend_q <= svc_req || (svc_pend_q && !(take && pick_lvl == 3'h0));
		end
	end

	// captured status for the handler
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			chk_code_q  <= PIC_CHK_NONE;
			chk_addr_q  <= '0;
			chk_level_q <= LVL_MAIN;
		end else if (chk_to_l7) begin
			chk_code_q  <= check_report.code;
			chk_addr_q  <= check_report.addr;
			chk_level_q <= cur_lvl;
		end else if (cs_invalid_addr && !stop_q) begin
			// the stopping cycle-steal address stays readable for the handler
			chk_addr_q  <= cs_addr;
		end
	end

	// hard stop and indicator
	// the first cause is kept until a clear; a later cause cannot overwrite it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stop_q      <= 1'b0;
			stop_code_q <= PIC_CHK_NONE;
		end else if (!stop_q && cs_invalid_addr) begin
			stop_q      <= 1'b1;
			stop_code_q <= PIC_CHK_CS_ADDR;
		end else if (!stop_q && chk_to_stop) begin
			stop_q      <= 1'b1;
			stop_code_q <= check_report.code;
		end else if (stop_clear) begin
			stop_q      <= 1'b0;
			stop_code_q <= PIC_CHK_NONE;
		end
	end

	// context registers, software through the selected slot
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < N_CTX; i++) begin
				ptr_q[i]  <= '0;
				hold_q[i] <= '0;
				mode_q[i] <= MODE_RST;
			end
		end else begin
			// sequencer writes the level in force; software goes through level_sel
			if (seq_ptr_we && !stop_q)
				ptr_q[cur_lvl] <= seq_ptr;
			if (seq_hold_we && !stop_q)
				hold_q[cur_lvl] <= seq_hold;
			if (apb_wr && sel_ok && paddr == OFS_NEXT_PTR)
				ptr_q[sel_idx] <= pwdata[ADDR_W-1:0];
			if (apb_wr && sel_ok && paddr == OFS_BR_HOLD)
				hold_q[sel_idx] <= pwdata[ADDR_W-1:0];
			if (apb_wr && sel_ok && paddr == OFS_MODE)
				mode_q[sel_idx] <= pwdata[MODE_W-1:0];
			if (s_load)
				ptr_q[LVL_MAIN] <= '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			level_sel_q <= LVL_MAIN;
		end else if (apb_wr && paddr == OFS_LEVEL_SEL) begin
			level_sel_q <= pwdata[3:0];
		end
	end

	// apb answer: one wait state, data registered
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !addr_ok;
			prdata  <= '0;
			// formed in the access cycle, so the data stands with pready
			if (apb_rd_phase && !pwrite) begin
				unique case (paddr)
					OFS_CTRL:      prdata <= {31'h0, pc_en_q};
					OFS_STATUS:    prdata <= {12'h0, s_attn, pc_pend_q, stop_q, 1'b0,
					                          in_level_q, 4'h0, cur_lvl};
					OFS_CHK_CODE:  prdata <= {29'h0, chk_code_q};
					OFS_CHK_ADDR:  prdata <= {13'h0, chk_addr_q};
					OFS_CHK_LEVEL: prdata <= {28'h0, chk_level_q};
					OFS_LEVEL_SEL: prdata <= {28'h0, level_sel_q};
					OFS_NEXT_PTR:  prdata <= sel_ok ? {16'h0, ptr_q[sel_idx]} : 32'h0;
					OFS_BR_HOLD:   prdata <= sel_ok ? {16'h0, hold_q[sel_idx]} : 32'h0;
					OFS_MODE:      prdata <= sel_ok ? {24'h0, mode_q[sel_idx]} : 32'h0;
					default:       prdata <= 32'h0;
				endcase
			end
		end
	end

	// attention and disk-not-ready handling
	logic adv_now;
	assign adv_now = insn_end && s_dnr && s_dual && !dnr_seen_q && !stop_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			attention_indicator   <= 1'b0;
			start_io_reject       <= 1'b0;
			advance_program_level <= 1'b0;
			repeat_instruction    <= 1'b0;
			dnr_seen_q            <= 1'b0;
		end else begin
			// processor keeps running, only starts refused
			attention_indicator   <= s_attn || s_dnr;
			start_io_reject       <= s_attn || s_dnr;
			// remembered until the drive is ready, so one advance per episode
			dnr_seen_q            <= s_dnr && (dnr_seen_q || adv_now);
			// without dual program, repeats last while the drive stays not ready
			advance_program_level <= adv_now;
			repeat_instruction    <= s_dnr && !s_dual && !stop_q;
		end
	end

	// sequencer-facing outputs
	logic [3:0] next_lvl;
	assign next_lvl = take ? {1'b0, pick_lvl} : cur_lvl;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			next_instruction_pointer <= '0;
			branch_address_holder    <= '0;
			active_level             <= LVL_MAIN;
			level_switch             <= 1'b0;
			proc_stop                <= 1'b0;
			check_indicator          <= 1'b0;
			stop_check_code          <= PIC_CHK_NONE;
			io_abort                 <= 1'b0;
		end else begin
			next_instruction_pointer <= ptr_q[next_lvl];
			branch_address_holder    <= hold_q[next_lvl];
			active_level             <= cur_lvl;
			level_switch             <= take;
			proc_stop                <= stop_q;
			check_indicator          <= stop_q;
			stop_check_code          <= stop_code_q;
			io_abort                 <= stop_q;
		end
	end

endmodule

// >>> dv/pic_ctrl_assertions.sv
`timescale 1ns/1ps
module pic_ctrl_assertions (
	// clock and bus
	input wire logic                sys_clk,
	input wire logic                sys_rst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	// causes
	input wire logic                insn_end,
	input wire logic                io_attention,
	input wire logic                check_reset_key,
	input wire logic                initial_program_load,
	input wire logic                cs_invalid_addr,
	// effects
	input wire logic [3:0]          active_level,
	input wire logic                level_switch,
	input wire logic                proc_stop,
	input wire logic                check_indicator,
	input wire logic                io_abort,
	input wire pic_pkg::pic_check_e stop_check_code,
	input wire logic                attention_indicator,
	input wire logic                start_io_reject,
	input wire logic                advance_program_level
);
	import pic_pkg::*;
	// rank by level number, main last
	localparam int RK [9] = '{7, 6, 4, 3, 2, 5, 1, 0, 8};
	wire logic clr = check_reset_key | initial_program_load;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	// active_level follows level_switch by one cycle
	level_rank_a: assert property (level_switch |=>
		RK[active_level] < RK[$past(active_level)])
		else $error("entered a lower level");
	switch_cause_a: assert property (level_switch |->
		$past(insn_end) || $past(insn_end, 2))
		else $error("switch without instruction end");
	stop_lamps_a: assert property (proc_stop |->
		check_indicator && io_abort && stop_check_code != PIC_CHK_NONE)
		else $error("stop without indicator");
	// sync delay on the keys lets the clear land up to five edges later
	stop_holds_a: assert property (proc_stop |=> proc_stop ||
		$past(clr, 2) || $past(clr, 3) || $past(clr, 4) || $past(clr, 5))
		else $error("stop cleared without cause");
	cs_stop_a: assert property (cs_invalid_addr && !proc_stop |->
		##2 proc_stop && stop_check_code == PIC_CHK_CS_ADDR)
		else $error("cycle steal address missed");
	attn_lamp_a: assert property ($past(io_attention, 3) && $past(io_attention, 4) |->
		attention_indicator && start_io_reject)
		else $error("attention not shown");
	adv_cause_a: assert property (advance_program_level |->
		$past(insn_end) || $past(insn_end, 2))
		else $error("advance without instruction end");
	adv_once_a: assert property (advance_program_level |=> !advance_program_level)
		else $error("advance longer than a pulse");
	cover property (level_switch && active_level == 4'h7);
	cover property ($rose(proc_stop));
	cover property (advance_program_level);
endmodule

bind pic_ctrl pic_ctrl_assertions u_chk (.*);

// >>> dv/pic_attach_model.sv
`timescale 1ns/1ps
module pic_attach_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// operation progress
	input wire logic op_done,
	input wire logic op_end_en,
	input wire logic serviced,
	// toward the processor
	output logic     op_end_req
);
	// a level, not a pulse: a pre-empted request must survive
	always_ff @(posedge sys_clk) begin
		if (sys_rst || serviced)
			op_end_req <= 1'h0;
		else if (op_done && op_end_en)
			op_end_req <= 1'h1;
	end
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
`define CK(g, x) begin \
	checks_done++; \
	if ((g) !== (x)) begin \
		n_errors++; \
		$display("BAD t=%0t got=%0h exp=%0h", $time, g, x); \
	end \
end
module tb;
	import pic_pkg::*;
	logic        sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        io_attention = 1'h0, disk_not_ready = 1'h0, check_reset_key = 1'h0;
	logic        initial_program_load = 1'h0, dual_program_active = 1'h0, insn_end = 1'h0;
	logic        svc_req = 1'h0, cs_invalid_addr = 1'h0, seq_ptr_we = 1'h0, seq_hold_we = 1'h0;
	logic        diskette_ready_req = 1'h0, op_done = 1'h0, serviced = 1'h0, op_end_req;
	logic        pready, pslverr, se, level_switch, proc_stop, check_indicator, io_abort;
	logic        attention_indicator, start_io_reject, advance_program_level, repeat_instruction;
	logic [3:0]  active_level;
	logic [4:0]  io_level_req;
	logic [7:0]  paddr = 8'h00, r = 8'h00;
	logic [15:0] seq_ptr = 16'h0, seq_hold = 16'h0, next_instruction_pointer;
	logic [15:0] branch_address_holder, hold_m, ptr_m [9];
	logic [18:0] cs_addr = 19'h0, a_m;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h53;
	pic_check_s  check_report = '0;
	pic_check_e  stop_check_code;
	int          n_errors = 0, checks_done = 0, cycles = 0, lsw_n = 0, adv_n = 0, e;
	int          lv [$], rk [8] = '{7, 6, 4, 3, 2, 5, 1, 0};

	assign io_level_req = {r[6], r[4:1]};
	pic_ctrl #(.HAS_LEVEL6(1'h1)) DUT (.*);
	pic_attach_model u_att (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_done(op_done),
		.op_end_en(1'h1), .serviced(serviced), .op_end_req(op_end_req));

	initial forever #5 sys_clk = ~sys_clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// model: pending level of best rank leaves the queue
	function automatic int best();
		int b;
		b = 0;
		foreach (lv[i])
			if (rk[lv[i]] < rk[lv[b]])
				b = i;
		best = lv[b];
		lv.delete(b);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1) @(posedge sys_clk);
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic step();
		@(posedge sys_clk) insn_end <= 1'h1;
		@(posedge sys_clk) insn_end <= 1'h0;
		cyc(1);
	endtask

	task automatic pchk(input pic_check_e c);
		@(posedge sys_clk) check_report <= '{1'h1, c, a_m};
		@(posedge sys_clk) check_report.valid <= 1'h0;
		cyc(3);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		lsw_n += (level_switch === 1'h1);
		adv_n += (advance_program_level === 1'h1);
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'h0;
		cyc(4);
		`CK({active_level, stop_check_code}, {LVL_MAIN, PIC_CHK_NONE})
		apb(1'h0, OFS_LEVEL_SEL, 32'h0);
		`CK(rd, 32'h8)
		apb(1'h0, 8'h40, 32'h0);
		`CK({se, rd}, {1'h1, 32'h0})
		for (int l = 0; l < 8; l++) begin
			ptr_m[l] = 16'(rnd());
			apb(1'h1, OFS_LEVEL_SEL, 32'(l));
			apb(1'h1, OFS_NEXT_PTR, {16'h0, ptr_m[l]});
		end
		ptr_m[8] = 16'(rnd());
		@(posedge sys_clk) seq_ptr <= ptr_m[8];
		seq_ptr_we <= 1'h1;
		@(posedge sys_clk) seq_ptr_we <= 1'h0;
		for (int l = 0; l < 9; l++) begin
			apb(1'h1, OFS_LEVEL_SEL, 32'(l));
			apb(1'h0, OFS_NEXT_PTR, 32'h0);
			`CK(rd, {16'h0, ptr_m[l]})
		end
		hold_m = 16'(rnd());
		apb(1'h1, OFS_BR_HOLD, {16'h0, hold_m});
		cyc(2);
		`CK(branch_address_holder, hold_m)
		hold_m = 16'(rnd());
		@(posedge sys_clk) seq_hold <= hold_m;
		seq_hold_we <= 1'h1;
		@(posedge sys_clk) seq_hold_we <= 1'h0;
		cyc(2);
		`CK(branch_address_holder, hold_m)
		$display("end registers");
		@(posedge sys_clk) io_attention <= 1'h1;
		cyc(5);
		`CK({attention_indicator, start_io_reject, proc_stop}, 3'h6)
		@(posedge sys_clk) io_attention <= 1'h0;
		disk_not_ready <= 1'h1;
		cyc(5);
		`CK({attention_indicator, repeat_instruction}, 2'h3)
		@(posedge sys_clk) dual_program_active <= 1'h1;
		cyc(4);
		step();
		step();
		`CK(adv_n, 1)
		@(posedge sys_clk) disk_not_ready <= 1'h0;
		dual_program_active <= 1'h0;
		cyc(5);
		`CK({attention_indicator, repeat_instruction}, 2'h0)
		$display("end attention");
		lv = '{0, 1, 2, 3, 4, 5, 6};
		@(posedge sys_clk) r <= 8'h5E;
		op_done <= 1'h1;
		svc_req <= 1'h1;
		@(posedge sys_clk) op_done <= 1'h0;
		svc_req <= 1'h0;
		cyc(4);
		while (lv.size() > 0) begin
			e = best();
			step();
			`CK(active_level, 4'(e))
			`CK(next_instruction_pointer, ptr_m[e])
			@(posedge sys_clk) r[e] <= 1'h0;
			serviced <= (e == 5);
			@(posedge sys_clk) serviced <= 1'h0;
			apb(1'h1, OFS_CTRL, 32'h8);
			cyc(4);
		end
		step();
		`CK({active_level, next_instruction_pointer}, {LVL_MAIN, ptr_m[8]})
		`CK(lsw_n, 7)
		$display("end priority");
		@(posedge sys_clk) r <= 8'h02;
		cyc(4);
		step();
		apb(1'h1, OFS_LEVEL_SEL, 32'h1);
		apb(1'h1, OFS_MODE, 32'h1);
		@(posedge sys_clk) r <= 8'h42;
		cyc(4);
		step();
		apb(1'h1, OFS_CTRL, 32'h8);
		cyc(2);
		`CK(active_level, 4'h1)
		apb(1'h1, OFS_MODE, 32'h0);
		step();
		`CK(active_level, 4'h6)
		apb(1'h1, OFS_LEVEL_SEL, 32'h6);
		apb(1'h1, OFS_MODE, 32'h1);
		apb(1'h1, OFS_CTRL, 32'h1);
		a_m = 19'(rnd());
		pchk(PIC_CHK_INV_OP);
		step();
		`CK(active_level, 4'h7)
		apb(1'h0, OFS_CHK_CODE, 32'h0);
		`CK(rd[2:0], PIC_CHK_INV_OP)
		apb(1'h0, OFS_CHK_ADDR, 32'h0);
		`CK(rd[18:0], a_m)
		apb(1'h0, OFS_CHK_LEVEL, 32'h0);
		`CK(rd[3:0], 4'h6)
		pchk(PIC_CHK_STOR_VIOL);
		`CK({proc_stop, check_indicator, io_abort}, 3'h7)
		@(posedge sys_clk) check_reset_key <= 1'h1;
		@(posedge sys_clk) check_reset_key <= 1'h0;
		cyc(6);
		`CK(proc_stop, 1'h0)
		apb(1'h1, OFS_CTRL, 32'h4);
		cyc(2);
		`CK(active_level, 4'h6)
		apb(1'h1, OFS_CTRL, 32'h2);
		@(posedge sys_clk) r <= 8'h00;
		for (int i = 0; i < 5; i++) begin
			pchk(pic_check_e'(i));
			`CK({proc_stop, stop_check_code}, {1'h1, 3'(i)})
			@(posedge sys_clk) initial_program_load <= 1'h1;
			@(posedge sys_clk) initial_program_load <= 1'h0;
			cyc(6);
			`CK({proc_stop, active_level}, {1'h0, LVL_MAIN})
		end
		a_m = 19'(rnd());
		@(posedge sys_clk) cs_invalid_addr <= 1'h1;
		cs_addr <= a_m;
		@(posedge sys_clk) cs_invalid_addr <= 1'h0;
		cyc(2);
		`CK({proc_stop, stop_check_code}, {1'h1, PIC_CHK_CS_ADDR})
		apb(1'h0, OFS_CHK_ADDR, 32'h0);
		`CK(rd[18:0], a_m)
		@(posedge sys_clk) sys_rst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'h0;
		cyc(2);
		`CK(proc_stop, 1'h0)
		$display("end checks");
		complete_run();
	end
endmodule
